// *** sptsb_status_bank.sv ***
// status bank: supply, thermal, device history and bus status flags
`timescale 1ns/1ps
`default_nettype none

// How it works
// - power-on sets bit seven; soft reset clears
// - sleep with regulator off blocks supply flags
// - undervoltage update gated by mode, 2ms override
// - over sixteen consecutive stage-two events set safe
// - stage-two event sets bit two, fail-safe
// - stage-one event sets bit one, module off
// - prewarning sets bit zero
// - thermal flags never clear by themselves
// - history field codes state before restart
// - sleep attempt with wake flags reports sleep
// - watchdog counter counts one or two, not three
// - only watchdog counter clears itself
// - configs two and four freeze counter until trigger
// - invalid command sets serial fail, clears by command
// - fail output activation sets failure bit
// - timeout sets bit four of bus status
// - system error bit blocks selective wake enable
// - can failure field codes four cases
// - reserved bits always read zero
// - can supply undervoltage sets bit zero, transmitter off
// - timeout clear blocked until interrupt falls
// - timeout set only in selective wake mode
module sptsb_status_bank (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic soft_reset,
  // device context
  input wire sptsb_pkg::sptsb_mode_e mode,
  input wire logic main_regulator_on,
  input wire logic reset_output_pin,
  input wire logic [1:0] configuration_select,
  input wire logic transceiver_mode_bit_two,
  input wire logic interrupt_output_pin,
  input wire logic selective_wake_request,
  // events
  input wire sptsb_pkg::sptsb_event_s evt,
  // serial register access
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  output logic [7:0] reg_rdata,
  // actions
  output logic fail_safe_request,
  output logic stage_one_module_off,
  output logic transmitter_disable,
  output logic long_thermal_stage_two_shutdown_wait,
  output logic selective_wake_enable
);

  sptsb_pkg::sptsb_state_s s_ff;
  sptsb_pkg::sptsb_state_s nxt_s;
  logic rd_sup;
  logic rd_th;
  logic rd_dev;
  logic rd_bus;
  logic sup_gate;
  logic uv_gate;
  logic uv_long;
  logic freeze_cfg;

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [6:0] a, input logic [6:0] b);
    hit = reg_rd && (a == b);
  endfunction : hit

  assign rd_sup = hit(reg_addr, sptsb_pkg::SUPPLY_STATUS_ADDR);
  assign rd_th = hit(reg_addr, sptsb_pkg::THERMAL_PROTECTION_STATUS_ADDR);
  assign rd_dev = hit(reg_addr, sptsb_pkg::DEVICE_HISTORY_STATUS_ADDR);
  assign rd_bus = hit(reg_addr, sptsb_pkg::BUS_COMMUNICATION_STATUS_ADDR);
  // supply flags blocked in sleep with regulator off
  assign sup_gate = !(mode == sptsb_pkg::SPTSB_SLEEP && !main_regulator_on);
  assign uv_long = s_ff.uv_cnt >= 32'(sptsb_pkg::UV_PERSIST_CYC);
  // config 2 and 4 have no pull-up: select codes 1 and 3
  assign freeze_cfg = configuration_select[0];

  always_comb begin
    unique case (mode)
      sptsb_pkg::SPTSB_RESTART: uv_gate = 1'b0;
      sptsb_pkg::SPTSB_INIT: uv_gate = reset_output_pin;
      default: uv_gate = 1'b1;
    endcase
    if (uv_long) begin
      uv_gate = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.intr_q = interrupt_output_pin;
    // persistence counter, saturating
    if (!evt.vcc_uv) begin
      nxt_s.uv_cnt = 32'h0;
    end else if (!uv_long) begin
      nxt_s.uv_cnt = s_ff.uv_cnt + 32'h1;
    end
    // clears first, events afterward so sets win
    if (rd_sup) begin
      nxt_s.sup = 8'h00;
    end
    if (rd_th) begin
      nxt_s.therm = 8'h00;
    end
    if (rd_dev) begin
      nxt_s.hist = sptsb_pkg::HIST_CLEARED;
      nxt_s.serial_fail = 1'b0;
      nxt_s.failure = 1'b0;
    end
    if (rd_bus) begin
      if (!s_ff.bus_timeout_flag_hold) begin
        nxt_s.bus_timeout_flag = 1'b0;
      end
      nxt_s.selective_wake_system_error = 1'b0;
      nxt_s.canf = sptsb_pkg::CANF_NONE;
      nxt_s.can_uv = 1'b0;
    end
    // supply
    if (sup_gate && evt.vcc_short) begin
      nxt_s.sup[sptsb_pkg::SUP_SHORT_BIT] = 1'b1;
    end
    if (sup_gate && evt.vcc_ov) begin
      nxt_s.sup[sptsb_pkg::SUP_OV_BIT] = 1'b1;
    end
    if (sup_gate && uv_gate && evt.vcc_uv) begin
      nxt_s.sup[sptsb_pkg::SUP_UV_BIT] = 1'b1;
    end
    // thermal: sticky, cleared by read or soft reset only
    if (evt.thermal_prewarning) begin
      nxt_s.therm[sptsb_pkg::TH_TPW_BIT] = 1'b1;
    end
    if (evt.thermal_stage_one_shutdown) begin
      nxt_s.therm[sptsb_pkg::TH_THERMAL_STAGE_ONE_SHUTDOWN_BIT] = 1'b1;
    end
    if (evt.thermal_stage_two_shutdown) begin
      nxt_s.therm[sptsb_pkg::TH_THERMAL_STAGE_TWO_SHUTDOWN_BIT] = 1'b1;
      if (s_ff.thermal_stage_two_shutdown_run != 5'h1F) begin
        nxt_s.thermal_stage_two_shutdown_run = s_ff.thermal_stage_two_shutdown_run + 5'h1;
      end
      if (s_ff.thermal_stage_two_shutdown_run >= sptsb_pkg::THERMAL_STAGE_TWO_SAFE_STATE_LIMIT) begin
        nxt_s.therm[sptsb_pkg::TH_SAFE_BIT] = 1'b1;
      end
    end else if (evt.thermal_stage_one_shutdown || evt.thermal_prewarning || evt.wd_trigger_ok) begin
      // a different thermal or healthy event breaks the run
      nxt_s.thermal_stage_two_shutdown_run = 5'h0;
    end
    // history before leaving restart
    if (evt.restart_sleep) begin
      nxt_s.hist = sptsb_pkg::HIST_SLEEP;
    end else if (evt.restart_failure) begin
      nxt_s.hist = sptsb_pkg::HIST_FAILURE;
    end
    // watchdog counter: the only self-clearing field
    if (evt.wd_trigger_ok) begin
      nxt_s.wd_frozen = 1'b0;
      nxt_s.wdc = 2'h0;
    end
    if (evt.watchdog_failure_counter && !s_ff.wd_frozen) begin
      if (s_ff.wdc != sptsb_pkg::WDC_TWO) begin
        nxt_s.wdc = s_ff.wdc + 2'h1;
      end
      nxt_s.wd_frozen = freeze_cfg;
    end
    if (evt.serial_invalid) begin
      nxt_s.serial_fail = 1'b1;
    end
    if (evt.fail_output) begin
      nxt_s.failure = 1'b1;
    end
    // bus
    if (s_ff.intr_q && !interrupt_output_pin) begin
      nxt_s.bus_timeout_flag_hold = 1'b0;
    end
    if (transceiver_mode_bit_two && evt.can_silent) begin
      nxt_s.bus_timeout_flag = 1'b1;
      nxt_s.bus_timeout_flag_hold = 1'b1;
    end
    if (transceiver_mode_bit_two && evt.sys_error) begin
      nxt_s.selective_wake_system_error = 1'b1;
    end
    if (evt.bus_dom) begin
      nxt_s.canf = sptsb_pkg::CANF_BUS;
    end else if (evt.txd_dom) begin
      nxt_s.canf = sptsb_pkg::CANF_TXD;
    end else if (evt.can_tsd) begin
      nxt_s.canf = sptsb_pkg::CANF_TSD;
    end
    if (evt.can_uv) begin
      nxt_s.can_uv = 1'b1;
    end
    if (soft_reset) begin
      nxt_s = '0;
      nxt_s.sup = sptsb_pkg::SUPPLY_SOFT_RESET;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.sup <= sptsb_pkg::SUPPLY_POR_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs; reserved bits driven zero
  // ---------------------------------------------------------------
  always_comb begin
    reg_rdata = 8'h00;
    if (rd_sup) begin
      reg_rdata = s_ff.sup & 8'h87;
    end else if (rd_th) begin
      reg_rdata = {4'h0, s_ff.therm[3:0]};
    end else if (rd_dev) begin
      reg_rdata = {s_ff.hist, 2'h0, s_ff.wdc, s_ff.serial_fail,
        s_ff.failure};
    end else if (rd_bus) begin
      reg_rdata = {3'h0, s_ff.bus_timeout_flag, s_ff.selective_wake_system_error, s_ff.canf, s_ff.can_uv};
    end
  end

  assign fail_safe_request = s_ff.therm[sptsb_pkg::TH_THERMAL_STAGE_TWO_SHUTDOWN_BIT];
  assign stage_one_module_off = s_ff.therm[sptsb_pkg::TH_THERMAL_STAGE_ONE_SHUTDOWN_BIT];
  // transmitter follows the live condition, not the sticky flag
  assign transmitter_disable = evt.can_uv;
  assign long_thermal_stage_two_shutdown_wait = s_ff.therm[sptsb_pkg::TH_SAFE_BIT];
  assign selective_wake_enable = selective_wake_request && !s_ff.selective_wake_system_error;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_tpw_sets: assert property (evt.thermal_prewarning && !soft_reset |=>
    s_ff.therm[0]) else $error("prewarning flag not set");
  chk_thermal_stage_two_shutdown_set: assert property (evt.thermal_stage_two_shutdown && !soft_reset |=>
    fail_safe_request) else $error("stage two not flagged");
  chk_thermal_sticky: assert property (s_ff.therm[1] && !rd_th &&
    !soft_reset |=> s_ff.therm[1]) else $error("thermal flag self cleared");
  chk_sleep_block: assert property (mode == sptsb_pkg::SPTSB_SLEEP &&
    !main_regulator_on && !s_ff.sup[2] |=> !s_ff.sup[2])
    else $error("short flag set in sleep");
  chk_restart_uv: assert property (mode == sptsb_pkg::SPTSB_RESTART &&
    !uv_long && !s_ff.sup[0] |=> !s_ff.sup[0])
    else $error("uv updated in restart");
  chk_wdc_never3: assert property (s_ff.wdc != 2'h3)
    else $error("watchdog counter reached three");
  chk_serial_win: assert property (evt.serial_invalid && rd_dev &&
    !soft_reset |=> s_ff.serial_fail) else $error("event lost to clear");
  chk_bus_timeout_flag_mode: assert property (!transceiver_mode_bit_two &&
    !s_ff.bus_timeout_flag |=> !s_ff.bus_timeout_flag) else $error("timeout without swk");
  chk_bus_timeout_flag_hold: assert property (s_ff.bus_timeout_flag_hold && s_ff.bus_timeout_flag &&
    !soft_reset |=> s_ff.bus_timeout_flag) else $error("timeout cleared early");
  chk_reserved: assert property (rd_th |-> reg_rdata[7:4] == 4'h0)
    else $error("reserved bits nonzero");
  chk_selective_wake_system_error_blk: assert property (s_ff.selective_wake_system_error |->
    !selective_wake_enable) else $error("swk enabled with error");

  // ---------------------------------------------------------------
  // event to flag checks; soft reset excluded since it wipes all
  // ---------------------------------------------------------------
  sequence sq_wd_frozen_idle;
    s_ff.wd_frozen && !evt.wd_trigger_ok && !soft_reset;
  endsequence

  sequence sq_safe_event;
    evt.thermal_stage_two_shutdown && (s_ff.thermal_stage_two_shutdown_run >= sptsb_pkg::THERMAL_STAGE_TWO_SAFE_STATE_LIMIT) && !soft_reset;
  endsequence

  chk_soft_clear: assert property (soft_reset |=>
    s_ff.sup == 8'h00 && s_ff.therm == 8'h00)
    else $error("soft reset left flags set");
  chk_thermal_stage_one_shutdown_set: assert property (evt.thermal_stage_one_shutdown && !soft_reset |=>
    stage_one_module_off) else $error("stage one not flagged");
  chk_safe_set: assert property (sq_safe_event |=>
    long_thermal_stage_two_shutdown_wait) else $error("safe state not flagged");
  chk_serial_set: assert property (evt.serial_invalid && !soft_reset
    |=> s_ff.serial_fail) else $error("serial fail not set");
  chk_failure_set: assert property (evt.fail_output && !soft_reset
    |=> s_ff.failure) else $error("failure bit not set");
  chk_canuv_set: assert property (evt.can_uv && !soft_reset |=>
    s_ff.can_uv) else $error("can supply flag not set");
  chk_bus_timeout_flag_set: assert property (transceiver_mode_bit_two &&
    evt.can_silent && !soft_reset |=> s_ff.bus_timeout_flag)
    else $error("timeout flag not set");
  chk_wdc_frozen: assert property (sq_wd_frozen_idle |=>
    $stable(s_ff.wdc)) else $error("frozen counter moved");
  chk_wdc_clear: assert property (evt.wd_trigger_ok && !evt.watchdog_failure_counter &&
    !soft_reset |=> s_ff.wdc == 2'h0) else $error("counter not cleared");
  chk_hist_sleep: assert property (evt.restart_sleep && !soft_reset
    |=> s_ff.hist == sptsb_pkg::HIST_SLEEP)
    else $error("sleep origin not kept");
  chk_canf_bus: assert property (evt.bus_dom && !soft_reset |=>
    s_ff.canf == sptsb_pkg::CANF_BUS) else $error("bus dominant lost");
  chk_init_uv: assert property (mode == sptsb_pkg::SPTSB_INIT &&
    !reset_output_pin && !uv_long && !s_ff.sup[0] |=> !s_ff.sup[0])
    else $error("uv updated before reset release");
  chk_dev_reserved: assert property (rd_dev |->
    reg_rdata[5:4] == 2'h0) else $error("device reserved bits nonzero");
  chk_bus_reserved: assert property (rd_bus |->
    reg_rdata[7:5] == 3'h0) else $error("bus reserved bits nonzero");
  chk_sup_reserved: assert property (rd_sup |->
    reg_rdata[6:3] == 4'h0) else $error("supply reserved bits nonzero");
  chk_tpw_sticky: assert property (s_ff.therm[0] && !rd_th &&
    !soft_reset |=> s_ff.therm[0]) else $error("prewarning self cleared");

endmodule : sptsb_status_bank

`default_nettype wire

// *** sptsb_pkg.sv ***
// package: offsets, field positions, reset values and timing of the status bank
package sptsb_pkg;

  // ---------------------------------------------------------------
  // register offsets (7-bit serial addresses)
  // ---------------------------------------------------------------
  localparam logic [6:0] SUPPLY_STATUS_ADDR = 7'h41;
  localparam logic [6:0] THERMAL_PROTECTION_STATUS_ADDR = 7'h42;
  localparam logic [6:0] DEVICE_HISTORY_STATUS_ADDR = 7'h43;
  localparam logic [6:0] BUS_COMMUNICATION_STATUS_ADDR = 7'h44;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SUP_POR_BIT = 7;
  localparam int SUP_SHORT_BIT = 2;
  localparam int SUP_UV_BIT = 0;
  localparam int SUP_OV_BIT = 1;
  localparam int TH_SAFE_BIT = 3;
  localparam int TH_THERMAL_STAGE_TWO_SHUTDOWN_BIT = 2;
  localparam int TH_THERMAL_STAGE_ONE_SHUTDOWN_BIT = 1;
  localparam int TH_TPW_BIT = 0;
  localparam int DEV_HIST_LSB = 6;
  localparam int DEV_WDC_LSB = 2;
  localparam int DEV_SERIAL_BIT = 1;
  localparam int DEV_FAIL_BIT = 0;
  localparam int BUS_TO_BIT = 4;
  localparam int BUS_SELECTIVE_WAKE_SYSTEM_ERROR_BIT = 3;
  localparam int BUS_CANF_LSB = 1;
  localparam int BUS_UV_BIT = 0;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] SUPPLY_POR_RESET = 8'h80;
  localparam logic [7:0] SUPPLY_SOFT_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] HIST_CLEARED = 2'h0;
  localparam logic [1:0] HIST_FAILURE = 2'h1;
  localparam logic [1:0] HIST_SLEEP = 2'h2;
  localparam logic [1:0] WDC_ONE = 2'h1;
  localparam logic [1:0] WDC_TWO = 2'h2;
  localparam logic [1:0] CANF_NONE = 2'h0;
  localparam logic [1:0] CANF_TSD = 2'h1;
  localparam logic [1:0] CANF_TXD = 2'h2;
  localparam logic [1:0] CANF_BUS = 2'h3;
  localparam logic [4:0] THERMAL_STAGE_TWO_SAFE_STATE_LIMIT = 5'h10;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int UV_PERSIST_MS = 2;
  localparam int UV_PERSIST_CYC = UV_PERSIST_MS * 1000 * CLK_MHZ;
  localparam int THERMAL_STAGE_TWO_SHUTDOWN_WAIT_S = 60;
  localparam int THERMAL_STAGE_TWO_SHUTDOWN_WAIT_MS = THERMAL_STAGE_TWO_SHUTDOWN_WAIT_S * 1000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    SPTSB_INIT = 5'h01,
    SPTSB_NORMAL = 5'h02,
    SPTSB_STOP = 5'h04,
    SPTSB_SLEEP = 5'h08,
    SPTSB_RESTART = 5'h10
  } sptsb_mode_e;

  typedef struct packed {
    logic thermal_prewarning;
    logic thermal_stage_one_shutdown;
    logic thermal_stage_two_shutdown;
    logic vcc_short;
    logic vcc_ov;
    logic vcc_uv;
    logic can_uv;
    logic can_tsd;
    logic txd_dom;
    logic bus_dom;
    logic can_silent;
    logic sys_error;
    logic serial_invalid;
    logic fail_output;
    logic watchdog_failure_counter;
    logic wd_trigger_ok;
    logic restart_failure;
    logic restart_sleep;
  } sptsb_event_s;

  typedef struct packed {
    logic [7:0] sup;
    logic [7:0] therm;
    logic [1:0] hist;
    logic [1:0] wdc;
    logic wd_frozen;
    logic serial_fail;
    logic failure;
    logic bus_timeout_flag;
    logic bus_timeout_flag_hold;
    logic selective_wake_system_error;
    logic [1:0] canf;
    logic can_uv;
    logic [4:0] thermal_stage_two_shutdown_run;
    logic [31:0] uv_cnt;
    logic intr_q;
  } sptsb_state_s;

endpackage : sptsb_pkg

// *** sptsb_host.sv ***
// host model: serial master reading one status byte at a time
`timescale 1ns/1ps
`default_nettype none
module sptsb_host (
  // clock
  input wire logic sys_clk,
  // register access
  output logic reg_rd,
  output logic [6:0] reg_addr,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_rd = 1'b0;
    reg_addr = 7'h00;
  end
  // data taken inside the strobe cycle, clear of the edge that clears it
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    #1 d = reg_rdata;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : sptsb_host
`default_nettype wire

// *** sptsb_status_bank_bench.sv ***
// bench: status bank read by a host model, directed and random cases
`timescale 1ns/1ps
`default_nettype none
module sptsb_status_bank_bench;
  logic sys_clk, rst, soft_reset, reg_on, rst_out, swk_on, intr, swk_req;
  logic reg_rd, fsr, off1, tx_off, long_wait, swk_en;
  logic [1:0] cfg;
  logic [6:0] reg_addr;
  logic [7:0] rdata, d;
  sptsb_pkg::sptsb_mode_e mode;
  sptsb_pkg::sptsb_event_s evt;
  int fail_count, n_compared;

  sptsb_status_bank sptsb_status_bank_i (
    .sys_clk(sys_clk), .rst(rst), .soft_reset(soft_reset), .mode(mode),
    .main_regulator_on(reg_on), .reset_output_pin(rst_out),
    .configuration_select(cfg), .transceiver_mode_bit_two(swk_on),
    .interrupt_output_pin(intr), .selective_wake_request(swk_req),
    .evt(evt), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(rdata),
    .fail_safe_request(fsr), .stage_one_module_off(off1),
    .transmitter_disable(tx_off), .long_thermal_stage_two_shutdown_wait(long_wait),
    .selective_wake_enable(swk_en)
  );
  sptsb_host sptsb_host_i (
    .sys_clk(sys_clk), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(rdata)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic chk(input logic [6:0] a, input logic [7:0] exp);
    sptsb_host_i.rd(a, d);
    cmp(d, exp);
  endtask : chk
  // one-cycle pulse on a single event; bit index counts up from the last struct member
  task automatic ev(input int b);
    @(negedge sys_clk);
    evt = sptsb_pkg::sptsb_event_s'(18'h1 << b);
    @(negedge sys_clk);
    evt = '0;
  endtask : ev
  task automatic sreset();
    @(negedge sys_clk);
    soft_reset = 1'b1;
    @(negedge sys_clk);
    soft_reset = 1'b0;
  endtask : sreset
  function automatic logic [7:0] wdc(input int n, input bit frz);
    if (frz)
      return (n > 0) ? 8'h04 : 8'h00;
    return (n > 2) ? 8'h08 : 8'(n << 2);
  endfunction : wdc
  task automatic wrap_up();
    $display("compared %0d, wrong %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    rst = 1'b1;
    soft_reset = 1'b0;
    evt = '0;
    mode = sptsb_pkg::SPTSB_NORMAL;
    reg_on = 1'b1;
    rst_out = 1'b1;
    cfg = 2'h0;
    swk_on = 1'b0;
    intr = 1'b1;
    swk_req = 1'b0;
    fail_count = 0;
    n_compared = 0;
    n = $urandom(32'h41D7);
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    chk(7'h41, 8'h80);
    chk(7'h41, 8'h00);
    for (int a = 8'h42; a <= 8'h44; a++)
      chk(7'(a), 8'h00);
    chk(7'($urandom_range(8'h7F, 8'h45)), 8'h00);
    mode = sptsb_pkg::SPTSB_SLEEP;
    reg_on = 1'b0;
    for (int b = 12; b <= 14; b++)
      ev(b);
    chk(7'h41, 8'h00);
    mode = sptsb_pkg::SPTSB_RESTART;
    reg_on = 1'b1;
    ev(12);
    chk(7'h41, 8'h00);
    mode = sptsb_pkg::SPTSB_INIT;
    rst_out = 1'b0;
    ev(12);
    chk(7'h41, 8'h00);
    rst_out = 1'b1;
    ev(12);
    chk(7'h41, 8'h01);
    mode = sptsb_pkg::SPTSB_NORMAL;
    ev(13);
    ev(14);
    chk(7'h41, 8'h06);
    // first three fixed, then random; flags must outlive the event
    for (int r = 0; r < 15; r++) begin
      n = (r < 3) ? r : $urandom_range(2, 0);
      ev(17 - n);
      repeat (3) @(negedge sys_clk);
      cmp(8'(fsr), 8'(n == 2));
      cmp(8'(off1), 8'(n == 1));
      chk(7'h42, 8'h01 << n);
      chk(7'h42, 8'h00);
    end
    ev(17);
    fork
      ev(17);
      chk(7'h42, 8'h01);
    join
    chk(7'h42, 8'h01);
    for (int k = 16; k <= 17; k++) begin
      sreset();
      chk(7'h41, 8'h00);
      repeat (k) ev(15);
      cmp(8'(long_wait), 8'(k > 16));
      chk(7'h42, (k > 16) ? 8'h0C : 8'h04);
    end
    for (int f = 0; f < 2; f++) begin
      cfg = 2'(f);
      n = $urandom_range(4, 1);
      repeat (n) ev(3);
      chk(7'h43, wdc(n, f[0]));
      chk(7'h43, wdc(n, f[0]));
      ev(2);
      chk(7'h43, 8'h00);
    end
    ev(5);
    ev(4);
    ev(1);
    chk(7'h43, 8'h43);
    chk(7'h43, 8'h00);
    ev(0);
    chk(7'h43, 8'h80);
    for (int b = 10; b >= 8; b--) begin
      ev(b);
      chk(7'h44, 8'((11 - b) << 1));
    end
    @(negedge sys_clk);
    evt.can_uv = 1'b1;
    @(negedge sys_clk);
    cmp(8'(tx_off), 8'h01);
    evt.can_uv = 1'b0;
    chk(7'h44, 8'h01);
    ev(7);
    chk(7'h44, 8'h00);
    swk_on = 1'b1;
    ev(7);
    chk(7'h44, 8'h10);
    chk(7'h44, 8'h10);
    intr = 1'b0;
    chk(7'h44, 8'h10);
    chk(7'h44, 8'h00);
    swk_req = 1'b1;
    ev(6);
    cmp(8'(swk_en), 8'h00);
    chk(7'h44, 8'h08);
    cmp(8'(swk_en), 8'h01);
    wrap_up();
  end
endmodule : sptsb_status_bank_bench
`default_nettype wire
